// ==== logic/lan_regs_pkg.sv ====
// Purpose: shared constants for the lan eeprom / management / receive register slice
// Assumes: 100 MHz system clock, 32-bit classic wishbone, one word per register index
// Notes: byte address of a register is four times its index
package lan_regs_pkg;
  // register indices; byte address = index * 4
  localparam logic [5:0] IDX_EEPROM = 6'h0e;
  localparam logic [5:0] IDX_MGMT = 6'h10;
  localparam logic [5:0] IDX_RXCNT = 6'h14;
  localparam logic [5:0] IDX_ERX = 6'h18;

  // eeprom_bitbang_control fields
  localparam int EE_SK_BIT = 0;
  localparam int EEPROM_SELECT_PIN_BIT = 1;
  localparam int EE_DI_BIT = 2;
  localparam int EE_DO_BIT = 3;
  localparam logic [7:0] EE_RESET = 8'h00;

  // phy_management_command fields
  localparam int MC_IE_BIT = 29;
  localparam int MC_RDY_BIT = 28;
  localparam int MC_OP_LSB = 26;
  localparam int MC_PHY_LSB = 21;
  localparam int MC_REG_LSB = 16;
  localparam logic [31:0] MC_RESET = 32'h0000_0000;
  localparam logic [31:0] MC_WMASK = 32'h3fff_ffff;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;

  localparam logic [31:0] RXCNT_RESET = 32'h0000_0000;
  localparam logic [7:0] ERX_RESET = 8'h00;

  // management frame layout, the most significant bit is the first bit on the wire
  localparam logic [31:0] PREAMBLE = 32'hffff_ffff;
  localparam logic [1:0] START_CODE = 2'b01;
  localparam logic [1:0] TA_WRITE = 2'b10;
  localparam logic [1:0] TA_READ = 2'b00;
  localparam logic [6:0] FRAME_LAST = 7'h3f;
  localparam logic [6:0] READ_RELEASE = 7'h2e;
  localparam logic [6:0] READ_DATA_FIRST = 7'h30;

  // management clock half period
  localparam int CLK_PERIOD_NS = 10;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // early receive: length field, header ahead of the payload, quad-word size
  localparam logic [15:0] ETH_HDR_BYTES = 16'h000e;
  localparam logic [15:0] ETH_MAX_LEN = 16'h05dc;
  localparam int QW_SHIFT = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_END = 3'b100
  } mgmt_state_t;
endpackage

// ==== logic/mgmt_serial_engine.sv ====
// Purpose: shifts one management read or write frame to the physical-layer chip
// Assumes: i_mdio_i already synchronised; start only taken while idle
// Notes: data changes while the management clock is low, read data sampled on its rise
module mgmt_serial_engine #(
  parameter int HALF_CYC = lan_regs_pkg::MDC_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_op_read,
  input wire logic [4:0] i_phy,
  input wire logic [4:0] i_reg,
  input wire logic [15:0] i_wdata,
  input wire logic i_mdio_i,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_mdc,
  output logic o_mdio_o,
  output logic o_mdio_oe
);
  // the divider is eight bits wide and a half period needs at least two cycles
  if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_bad_half
    $error("HALF_CYC out of range");
  end

  lan_regs_pkg::mgmt_state_t state_r;
  logic [7:0] div_r;
  logic [6:0] bit_r;
  logic [63:0] tx_r;
  logic [15:0] rx_r;
  logic rd_r;
  logic mdc_r;
  logic oe_r;

  wire tick = (div_r == 8'(HALF_CYC - 1));
  wire running = (state_r == lan_regs_pkg::ST_RUN);
  wire [6:0] bit_inc = bit_r + 7'h01;
  wire [1:0] op_code = i_op_read ? lan_regs_pkg::OP_READ : lan_regs_pkg::OP_WRITE;
  wire [1:0] ta_code = i_op_read ? lan_regs_pkg::TA_READ : lan_regs_pkg::TA_WRITE;
  // preamble, start, opcode, phy, register, turnaround, data
  wire [63:0] frame = {lan_regs_pkg::PREAMBLE, lan_regs_pkg::START_CODE, op_code,
                       i_phy, i_reg, ta_code, i_wdata};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= lan_regs_pkg::ST_IDLE;
    end else begin
      case (state_r)
        lan_regs_pkg::ST_IDLE: if (i_start) state_r <= lan_regs_pkg::ST_RUN;
        lan_regs_pkg::ST_RUN: if (tick && mdc_r && bit_r == lan_regs_pkg::FRAME_LAST) state_r <= lan_regs_pkg::ST_END;
        lan_regs_pkg::ST_END: state_r <= lan_regs_pkg::ST_IDLE;
        default: state_r <= lan_regs_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 8'h00;
    end else begin
      div_r <= (!running || tick) ? 8'h00 : div_r + 8'h01;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_r <= 64'h0;
      bit_r <= 7'h00;
      rd_r <= 1'b0;
      mdc_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (state_r == lan_regs_pkg::ST_IDLE && i_start) begin
      tx_r <= frame;
      bit_r <= 7'h00;
      rd_r <= i_op_read;
      oe_r <= 1'b1;
    end else if (running && tick) begin
      mdc_r <= !mdc_r;
      if (mdc_r && bit_r != lan_regs_pkg::FRAME_LAST) begin
        bit_r <= bit_inc;
        tx_r <= {tx_r[62:0], 1'b0};
        // a read hands the line to the chip from the turnaround on
        oe_r <= !(rd_r && bit_inc >= lan_regs_pkg::READ_RELEASE);
      end
    end else if (!running) begin
      oe_r <= 1'b0;
      mdc_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_r <= 16'h0000;
    end else if (running && tick && !mdc_r && rd_r && bit_r >= lan_regs_pkg::READ_DATA_FIRST) begin
      rx_r <= {rx_r[14:0], i_mdio_i};
    end
  end

  assign o_busy = (state_r != lan_regs_pkg::ST_IDLE);
  assign o_done = (state_r == lan_regs_pkg::ST_END);
  assign o_rdata = rx_r;
  assign o_mdc = mdc_r;
  assign o_mdio_o = tx_r[63];
  assign o_mdio_oe = oe_r;

  sequence s_launch;
    state_r == lan_regs_pkg::ST_IDLE && i_start;
  endsequence

  sequence s_frame_busy;
    o_busy[*8];
  endsequence

  a_frame_stays_busy: assert property (@(posedge i_clk) disable iff (i_rst)
    s_launch |=> s_frame_busy)
    else $error("engine left a frame early");

  a_read_line_released: assert property (@(posedge i_clk) disable iff (i_rst)
    (running && rd_r && bit_r > lan_regs_pkg::READ_RELEASE) |-> !o_mdio_oe)
    else $error("engine drives the line during read data");

  a_op_on_wire: assert property (@(posedge i_clk) disable iff (i_rst)
    s_launch |=> (tx_r[29:28] == (rd_r ? lan_regs_pkg::OP_READ : lan_regs_pkg::OP_WRITE)))
    else $error("opcode bits wrong in frame");
endmodule

// ==== logic/lan_eeprom_mdi_rx_regs.sv ====
// Purpose: eeprom bit-bang port, phy management command, rx dma byte count, early receive
// Assumes: classic wishbone slave on I_CLK_SYS; receive strobes come from logic on the same clock
// Notes: every access is answered one cycle after the request, unmapped ones read zero
//
// The implementer's own choice: the Wishbone register port.
module lan_eeprom_mdi_rx_regs #(
  parameter int MDC_HALF = lan_regs_pkg::MDC_HALF_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT_I,
  output logic [31:0] O_WB_DAT_O,
  output logic O_WB_ACK,
  output logic O_EE_SELECT,
  output logic O_EE_SHIFT_CLK,
  output logic O_EE_TO_CHIP,
  input wire logic I_EE_FROM_CHIP,
  output logic O_MDC,
  output logic O_MDIO_O,
  output logic O_MDIO_OE,
  input wire logic I_MDIO_I,
  input wire logic I_RX_DMA_BYTE_STB,
  input wire logic I_RX_FRAME_START,
  input wire logic I_RX_BYTE_STB,
  input wire logic I_RX_LEN_VALID,
  input wire logic [15:0] I_RX_TYPE_LEN,
  input wire logic I_RX_FRAME_END,
  output logic O_MGMT_DONE_EVT,
  output logic O_EARLY_RX_EVT,
  output logic O_FRAME_RX_EVT
);
  function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] wdat,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[i*8 +: 8] = wdat[i*8 +: 8];
    end
    return res;
  endfunction

  // pin synchronisers; first stages feed only the second
  logic ee_s1_r, ee_s2_r, md_s1_r, md_s2_r;
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ee_s1_r <= 1'b0;
      ee_s2_r <= 1'b0;
      md_s1_r <= 1'b0;
      md_s2_r <= 1'b0;
    end else begin
      ee_s1_r <= I_EE_FROM_CHIP;
      ee_s2_r <= ee_s1_r;
      md_s1_r <= I_MDIO_I;
      md_s2_r <= md_s1_r;
    end
  end

  // bus slave: one wait state, ack drops the cycle after it rises
  logic ack_r;
  logic [31:0] dat_r;
  wire req = I_WB_CYC && I_WB_STB;
  wire take = req && !ack_r;
  wire wr_en = take && I_WB_WE;
  wire [5:0] idx = I_WB_ADR[7:2];
  wire hit_ee = (idx == lan_regs_pkg::IDX_EEPROM);
  wire hit_mc = (idx == lan_regs_pkg::IDX_MGMT);
  wire hit_cnt = (idx == lan_regs_pkg::IDX_RXCNT);
  wire hit_erx = (idx == lan_regs_pkg::IDX_ERX);

  // eeprom bit-bang port
  logic eeprom_select_pin_r, ee_sk_r, ee_di_r;
  wire ee_wr = wr_en && hit_ee && I_WB_SEL[0];
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      eeprom_select_pin_r <= lan_regs_pkg::EE_RESET[lan_regs_pkg::EEPROM_SELECT_PIN_BIT];
      ee_sk_r <= lan_regs_pkg::EE_RESET[lan_regs_pkg::EE_SK_BIT];
      ee_di_r <= lan_regs_pkg::EE_RESET[lan_regs_pkg::EE_DI_BIT];
    end else if (ee_wr) begin
      eeprom_select_pin_r <= I_WB_DAT_I[lan_regs_pkg::EEPROM_SELECT_PIN_BIT];
      ee_sk_r <= I_WB_DAT_I[lan_regs_pkg::EE_SK_BIT];
      ee_di_r <= I_WB_DAT_I[lan_regs_pkg::EE_DI_BIT];
    end
  end
  // select and clock timing are left to software; the pins follow the bits directly
  assign O_EE_SELECT = eeprom_select_pin_r;
  assign O_EE_SHIFT_CLK = ee_sk_r;
  assign O_EE_TO_CHIP = ee_di_r;
  // data-in bit is write-only and reads back as zero
  wire [31:0] ee_rd = {28'h0, ee_s2_r, 1'b0, eeprom_select_pin_r, ee_sk_r};

  // management command register
  logic [31:0] mc_r;
  logic [31:0] mc_nxt;
  logic bad_op_r;
  logic eng_busy, eng_done;
  logic [15:0] eng_rdata;
  wire [31:0] mc_merged = merge_lanes(mc_r, I_WB_DAT_I, I_WB_SEL) & lan_regs_pkg::MC_WMASK;
  // writes while a frame runs are dropped so the frame fields stay intact
  wire mc_wr = wr_en && hit_mc && !eng_busy;
  wire mc_launch = mc_wr && I_WB_SEL[3];
  wire [1:0] new_op = mc_merged[lan_regs_pkg::MC_OP_LSB +: 2];
  wire op_ok = (new_op == lan_regs_pkg::OP_WRITE) || (new_op == lan_regs_pkg::OP_READ);
  wire eng_start = mc_launch && op_ok;
  wire mc_finish = eng_done || bad_op_r;
  wire cur_read = (mc_r[lan_regs_pkg::MC_OP_LSB +: 2] == lan_regs_pkg::OP_READ);

  always_comb begin
    mc_nxt = mc_r;
    if (mc_wr) mc_nxt = mc_merged;
    if (eng_done && cur_read) mc_nxt[15:0] = eng_rdata;
    // the hardware set wins over a software clear in the same cycle
    if (mc_finish) mc_nxt[lan_regs_pkg::MC_RDY_BIT] = 1'b1;
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      mc_r <= lan_regs_pkg::MC_RESET;
      bad_op_r <= 1'b0;
      O_MGMT_DONE_EVT <= 1'b0;
    end else begin
      mc_r <= mc_nxt;
      bad_op_r <= mc_launch && !op_ok;
      O_MGMT_DONE_EVT <= mc_finish && mc_r[lan_regs_pkg::MC_IE_BIT];
    end
  end

  mgmt_serial_engine #(
    .HALF_CYC(MDC_HALF)
  ) u_engine (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_start(eng_start),
    .i_op_read(new_op == lan_regs_pkg::OP_READ),
    .i_phy(mc_merged[lan_regs_pkg::MC_PHY_LSB +: 5]),
    .i_reg(mc_merged[lan_regs_pkg::MC_REG_LSB +: 5]),
    .i_wdata(mc_merged[15:0]),
    .i_mdio_i(md_s2_r),
    .o_busy(eng_busy),
    .o_done(eng_done),
    .o_rdata(eng_rdata),
    .o_mdc(O_MDC),
    .o_mdio_o(O_MDIO_O),
    .o_mdio_oe(O_MDIO_OE)
  );

  // receive dma byte count, read-only
  logic [31:0] rxcnt_r;
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      rxcnt_r <= lan_regs_pkg::RXCNT_RESET;
    end else if (I_RX_DMA_BYTE_STB) begin
      rxcnt_r <= rxcnt_r + 32'h1;
    end
  end

  // early receive threshold
  logic [7:0] erx_r;
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      erx_r <= lan_regs_pkg::ERX_RESET;
    end else if (wr_en && hit_erx && I_WB_SEL[0]) begin
      erx_r <= I_WB_DAT_I[7:0];
    end
  end

  // frame tracking; a type value instead of a length never arms the early event
  logic [15:0] frm_bytes_r, frm_expect_r;
  logic armed_r, fired_r;
  wire [15:0] remaining = (frm_expect_r > frm_bytes_r) ? frm_expect_r - frm_bytes_r : 16'h0000;
  wire [15:0] erx_bytes = {5'h00, erx_r, 3'b000};
  wire early_hit = armed_r && !fired_r && (erx_r != 8'h00) && (remaining <= erx_bytes);

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      frm_bytes_r <= 16'h0000;
      frm_expect_r <= 16'h0000;
      armed_r <= 1'b0;
      fired_r <= 1'b0;
    end else if (I_RX_FRAME_START) begin
      frm_bytes_r <= 16'h0000;
      armed_r <= 1'b0;
      fired_r <= 1'b0;
    end else begin
      if (I_RX_BYTE_STB) frm_bytes_r <= frm_bytes_r + 16'h0001;
      if (I_RX_LEN_VALID && I_RX_TYPE_LEN <= lan_regs_pkg::ETH_MAX_LEN) begin
        frm_expect_r <= I_RX_TYPE_LEN + lan_regs_pkg::ETH_HDR_BYTES;
        armed_r <= 1'b1;
      end
      if (early_hit) fired_r <= 1'b1;
      if (I_RX_FRAME_END) armed_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_EARLY_RX_EVT <= 1'b0;
      O_FRAME_RX_EVT <= 1'b0;
    end else begin
      O_EARLY_RX_EVT <= early_hit;
      O_FRAME_RX_EVT <= I_RX_FRAME_END;
    end
  end

  // read mux and answer
  wire [31:0] rd_mux = hit_ee ? ee_rd :
                       hit_mc ? mc_r :
                       hit_cnt ? rxcnt_r :
                       hit_erx ? {24'h0, erx_r} : 32'h0;
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= take;
      if (take && !I_WB_WE) dat_r <= rd_mux;
    end
  end
  assign O_WB_ACK = ack_r;
  assign O_WB_DAT_O = dat_r;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  a_ee_data_out: assert property ((take && !I_WB_WE && hit_ee) |=> O_WB_DAT_O[3] == $past(ee_s2_r))
    else $error("eeprom data bit not read back");
  a_ee_data_in: assert property (ee_wr |=> O_EE_TO_CHIP == $past(I_WB_DAT_I[2]))
    else $error("eeprom data-in pin wrong");
  a_ee_select_pin: assert property (ee_wr |=> O_EE_SELECT == $past(I_WB_DAT_I[1]))
    else $error("eeprom select pin wrong");
  a_ee_clock_pin: assert property (ee_wr |=> O_EE_SHIFT_CLK == $past(I_WB_DAT_I[0]))
    else $error("eeprom clock pin wrong");
  a_launch_msb_only: assert property ((mc_wr && !I_WB_SEL[3]) |=> !eng_busy)
    else $error("command launched without top byte");
  a_ready_on_done: assert property (eng_done |=> mc_r[lan_regs_pkg::MC_RDY_BIT])
    else $error("ready not set after frame");
  a_done_event_gate: assert property (O_MGMT_DONE_EVT |-> $past(mc_r[lan_regs_pkg::MC_IE_BIT] && mc_finish))
    else $error("done event without enable");
  a_count_step: assert property (I_RX_DMA_BYTE_STB |=> rxcnt_r == $past(rxcnt_r) + 32'h1)
    else $error("dma byte count did not step");
  a_early_zero_off: assert property ((erx_r == 8'h00) |=> !O_EARLY_RX_EVT)
    else $error("early event with zero threshold");
  a_frame_end_event: assert property (I_RX_FRAME_END |=> O_FRAME_RX_EVT)
    else $error("no event at frame end");

  // multi-step checks: one-cycle bus answer, and a reserved opcode closing without a frame
  sequence s_ack_pulse;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  sequence s_bad_op_close;
    !eng_busy ##1 mc_r[lan_regs_pkg::MC_RDY_BIT];
  endsequence

  a_bus_ack_pulse: assert property (take |=> s_ack_pulse)
    else $error("bus answer not a single pulse");
  a_launch_starts: assert property (eng_start |=> eng_busy)
    else $error("launch did not start a frame");
  a_reserved_no_frame: assert property ((mc_launch && !op_ok) |=> s_bad_op_close)
    else $error("reserved opcode handled wrongly");
  a_ready_cleared: assert property ((eng_start && !I_WB_DAT_I[lan_regs_pkg::MC_RDY_BIT])
    |=> !mc_r[lan_regs_pkg::MC_RDY_BIT])
    else $error("ready not cleared by new command");
  a_read_data_lands: assert property ((eng_done && cur_read) |=> mc_r[15:0] == $past(eng_rdata))
    else $error("read data not placed in low half");
  a_busy_write_drop: assert property ((wr_en && hit_mc && eng_busy) |=> $stable(mc_r[27:16]))
    else $error("command fields changed during a frame");
  a_count_read_only: assert property (!I_RX_DMA_BYTE_STB |=> $stable(rxcnt_r))
    else $error("dma byte count moved without a strobe");
  a_early_single: assert property (O_EARLY_RX_EVT |=> !O_EARLY_RX_EVT)
    else $error("early event repeated");
  a_done_pulse: assert property (O_MGMT_DONE_EVT |=> !O_MGMT_DONE_EVT)
    else $error("done event longer than one cycle");
  a_select_holds: assert property (!ee_wr |=> $stable(O_EE_SELECT))
    else $error("eeprom select moved without a write");
  a_clock_holds: assert property (!ee_wr |=> $stable(O_EE_SHIFT_CLK))
    else $error("eeprom clock moved without a write");
  a_data_in_holds: assert property (!ee_wr |=> $stable(O_EE_TO_CHIP))
    else $error("eeprom data-in moved without a write");
endmodule

// ==== test/lan_far_side_model.sv ====
// Purpose: far side model: serial eeprom and management-port phy
// Assumes: eeprom shifts out one pattern bit per shift-clock rise while selected
// Notes: the management line has a pull-up, so a released line reads 1
module lan_far_side_model #(
  parameter logic [7:0] EE_PAT = 8'hb4,
  parameter logic [15:0] RD_VAL = 16'h5e71
) (
  input wire logic i_ee_select,
  input wire logic i_ee_shift_clk,
  output logic o_ee_data,
  input wire logic i_mdc,
  input wire logic i_mdio_o,
  input wire logic i_mdio_oe,
  output logic o_mdio_line,
  output logic [63:0] o_frame,
  output int o_frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ee_idx = 3'h0;
  logic ee_bit = 1'b0;
  logic [63:0] sh = 64'h0;
  int cnt = 0;
  logic rd_op = 1'b0;
  logic drv = 1'b0;
  logic val = 1'b1;
  initial begin
    o_frame = 64'h0;
    o_frames = 0;
  end
  always @(posedge i_ee_shift_clk) begin
    if (i_ee_select) begin
      ee_bit <= EE_PAT[ee_idx];
      ee_idx <= ee_idx + 3'h1;
    end
  end
  // deselected chip floats; show the inverse so stale data never looks valid
  assign o_ee_data = i_ee_select ? ee_bit : ~ee_bit;
  assign o_mdio_line = i_mdio_oe ? i_mdio_o : (drv ? val : 1'b1);
  always @(posedge i_mdc) begin
    sh <= {sh[62:0], o_mdio_line};
    if (cnt == 35) rd_op <= ({sh[0], o_mdio_line} == 2'b10);
    if (cnt == 63) begin
      o_frame <= {sh[62:0], o_mdio_line};
      o_frames <= o_frames + 1;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // phy changes data only while the clock is low
  always @(negedge i_mdc) begin
    drv <= rd_op && cnt >= 47;
    val <= (cnt < 48) ? 1'b0 : RD_VAL[63 - cnt];
  end
endmodule

// ==== test/tb_lan_eeprom_mdi_rx_regs.sv ====
// Purpose: register-level test of eeprom port, management command, rx count, early receive
// Assumes: default management clock divider; classic wishbone master
// Notes: expected frames are rebuilt here from the command fields
module tb_lan_eeprom_mdi_rx_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_EE = {lan_regs_pkg::IDX_EEPROM, 2'b00};
  localparam logic [7:0] A_MC = {lan_regs_pkg::IDX_MGMT, 2'b00};
  localparam logic [7:0] A_RX = {lan_regs_pkg::IDX_RXCNT, 2'b00};
  localparam logic [7:0] A_ER = {lan_regs_pkg::IDX_ERX, 2'b00};
  localparam logic [15:0] RDV = 16'h5e71;
  localparam logic [7:0] PAT = 8'hb4;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rdat, r, w;
  logic ack, ee_sel, ee_clk, ee_di, ee_do, mdc, mo, moe, mline, done_e, erx_e, frx_e;
  logic dma = 1'b0, fst = 1'b0, bst = 1'b0, lv = 1'b0, fend = 1'b0;
  logic [15:0] tl = 16'h0;
  logic [63:0] frame;
  int nfr, num_errors = 0, checks = 0, cycles = 0, dcnt = 0, ecnt = 0, fcnt = 0, nb = 0, e_at = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  lan_eeprom_mdi_rx_regs dut (.I_CLK_SYS(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT_I(wd), .O_WB_DAT_O(rdat),
    .O_WB_ACK(ack), .O_EE_SELECT(ee_sel), .O_EE_SHIFT_CLK(ee_clk), .O_EE_TO_CHIP(ee_di),
    .I_EE_FROM_CHIP(ee_do), .O_MDC(mdc), .O_MDIO_O(mo), .O_MDIO_OE(moe), .I_MDIO_I(mline),
    .I_RX_DMA_BYTE_STB(dma), .I_RX_FRAME_START(fst), .I_RX_BYTE_STB(bst), .I_RX_LEN_VALID(lv),
    .I_RX_TYPE_LEN(tl), .I_RX_FRAME_END(fend), .O_MGMT_DONE_EVT(done_e),
    .O_EARLY_RX_EVT(erx_e), .O_FRAME_RX_EVT(frx_e));

  lan_far_side_model #(.EE_PAT(PAT), .RD_VAL(RDV)) far (.i_ee_select(ee_sel),
    .i_ee_shift_clk(ee_clk), .o_ee_data(ee_do), .i_mdc(mdc), .i_mdio_o(mo), .i_mdio_oe(moe),
    .o_mdio_line(mline), .o_frame(frame), .o_frames(nfr));

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (done_e === 1'b1) dcnt <= dcnt + 1;
    if (erx_e === 1'b1) begin
      ecnt <= ecnt + 1;
      e_at <= nb;
    end
    if (frx_e === 1'b1) fcnt <= fcnt + 1;
    if (cycles == LIMIT) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  task chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task conclude();
    $display("num_errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= a;
    sel <= s;
    wd <= d;
    do @(posedge clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // plain read, the word lands in r at the edge that sees ack
  task bus_rd(input logic [7:0] a);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b0;
    adr <= a;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a);
    chk(r, e);
  endtask

  // polls until ready without comparing; the timeout cuts a hang
  task poll();
    do bus_rd(A_MC); while (r[28] !== 1'b1);
  endtask

  function automatic logic [63:0] fr(input logic [1:0] op, input logic [9:0] ad, input logic [15:0] d);
    return {32'hffff_ffff, 2'b01, op, ad, 2'b10, d};
  endfunction

  // bytes spaced four cycles apart so an event is seen before the next byte
  task rx_frame();
    @(posedge clk) fst <= 1'b1;
    @(posedge clk) begin
      fst <= 1'b0;
      lv <= 1'b1;
      tl <= 16'h002e;
    end
    @(posedge clk) lv <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk) begin
        bst <= 1'b1;
        nb <= i + 1;
      end
      @(posedge clk) bst <= 1'b0;
      repeat (2) @(posedge clk);
    end
    @(posedge clk) fend <= 1'b1;
    @(posedge clk) fend <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(A_EE, 32'h0);
    rd(A_MC, 32'h0);
    rd(A_RX, 32'h0);
    rd(A_ER, 32'h0);
    wr(8'h44, 4'hf, 32'hffff_ffff);
    rd(8'h44, 32'h0);
    wr(A_EE, 4'h1, 32'h02);
    for (int k = 0; k < 3; k++) begin
      wr(A_EE, 4'h1, 32'h03);
      repeat (4) @(posedge clk);
      chk({ee_sel, ee_clk}, 2'b11);
      rd(A_EE, {28'h0, PAT[k], 3'b011});
      wr(A_EE, 4'h1, 32'h06);
      repeat (4) @(posedge clk);
      chk({ee_clk, ee_di}, 2'b01);
      rd(A_EE, {28'h0, PAT[k], 3'b010});
    end
    wr(A_EE, 4'h1, 32'h00);
    repeat (4) @(posedge clk);
    chk({ee_sel, ee_clk, ee_di}, 3'b000);
    repeat (100) @(posedge clk);
    w = {2'b00, 1'b1, 1'b0, lan_regs_pkg::OP_WRITE, 5'h0b, 5'h04, 16'hc3a5};
    for (int b = 0; b < 3; b++) wr(A_MC, 4'h1 << b, w);
    repeat (50) @(posedge clk);
    chk(nfr, 0);
    rd(A_MC, {8'h0, w[23:0]});
    wr(A_MC, 4'h8, w);
    wr(A_MC, 4'hf, 32'h0);
    poll();
    chk(r, w | 32'h1000_0000);
    chk(frame, fr(2'b01, 10'h164, 16'hc3a5));
    repeat (3) @(posedge clk);
    chk(dcnt, 1);
    w = {2'b00, 1'b0, 1'b0, lan_regs_pkg::OP_READ, 5'h11, 5'h1f, 16'h0};
    wr(A_MC, 4'hf, w);
    poll();
    chk(r, {w[31:29], 1'b1, w[27:16], RDV});
    chk(frame, fr(2'b10, 10'h23f, RDV));
    repeat (3) @(posedge clk);
    chk(dcnt, 1);
    for (int c = 0; c < 4; c += 3) begin
      wr(A_MC, 4'hf, {2'b00, 1'b1, 1'b0, c[1:0], 26'h0});
      poll();
    end
    repeat (3) @(posedge clk);
    chk({nfr[7:0], dcnt[7:0]}, 16'h0203);
    repeat (5) begin
      @(posedge clk) dma <= 1'b1;
      @(posedge clk) dma <= 1'b0;
    end
    rd(A_RX, 32'h5);
    wr(A_RX, 4'hf, 32'h1234);
    rd(A_RX, 32'h5);
    wr(A_ER, 4'h1, 32'h02);
    rd(A_ER, 32'h02);
    rx_frame();
    chk({ecnt[7:0], e_at[7:0], fcnt[7:0]}, 24'h012c01);
    wr(A_ER, 4'h1, 32'h00);
    rx_frame();
    chk({ecnt[7:0], fcnt[7:0]}, 16'h0102);
    conclude();
  end
endmodule
